// [hdl/fpid_defs.svh]
// Opcodes, phase lengths and timing figures of the power-down/ID link
`ifndef FPID_DEFS_SVH
`define FPID_DEFS_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FPID_OP_PD 8'hb9
`define FPID_OP_REL_EID 8'hab
`define FPID_OP_MD 8'h90
`define FPID_OP_MD_DUAL 8'h92
`define FPID_OP_MD_QUAD 8'h94
`define FPID_OP_UID 8'h4b
`define FPID_OP_JID 8'h9f

// ----------------------------------------------------------------
// Phase lengths in serial clocks, lane counts and mode bits value
// ----------------------------------------------------------------
`define FPID_OPC_CLKS 7'h08
`define FPID_OPC_LAST 7'h07
`define FPID_ADDR_CLKS_1 6'h18
`define FPID_IN_CLKS_DUAL 6'h10
`define FPID_IN_CLKS_QUAD 6'h08
`define FPID_DUMMY_QUAD 6'h04
`define FPID_DUMMY_EID 6'h18
`define FPID_DUMMY_UID 6'h20
`define FPID_LANES_1 3'h1
`define FPID_LANES_2 3'h2
`define FPID_LANES_4 3'h4
`define FPID_MODE_BITS_VAL 8'hf0

// ----------------------------------------------------------------
// Output sequences
// ----------------------------------------------------------------
`define FPID_LEN_EID 7'h08
`define FPID_LEN_MD 7'h10
`define FPID_LEN_JID 7'h18
`define FPID_LEN_UID 7'h40
`define FPID_SRC_TOP 7'h43

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPID_CLK_MHZ 10
`define FPID_NS_PER_US 1000

`endif

// [hdl/fpid_dev.sv]
// Device end: power-down control and identification reads
`timescale 1ns/100ps
`include "fpid_defs.svh"

module fpid_dev
	import fpid_pkg::*;
#(
	parameter int T_DP_NS = 3000,
	parameter int T_RES1_NS = 3000,
	parameter int T_RES2_NS = 1800,
	// Identity values below are arbitrary
	parameter logic [7:0] MFR_ID = 8'h5a,
	parameter logic [7:0] DEV_ID = 8'h13,
	parameter logic [7:0] MEM_TYPE = 8'h60,
	parameter logic [7:0] CAPACITY = 8'h14,
	parameter logic [7:0] ELEC_ID = 8'h13,
	parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef
) (
	input wire logic mclk,
	input wire logic nrst,
	fpid_if.dev lnk,
	input wire logic busy,
	output logic powered_down,
	output logic accepting
);

	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam int DP_RAW = T_DP_NS * `FPID_CLK_MHZ / `FPID_NS_PER_US;
	localparam int RES1_RAW = (T_RES1_NS * `FPID_CLK_MHZ +
		`FPID_NS_PER_US - 1) / `FPID_NS_PER_US;
	localparam int RES2_RAW = (T_RES2_NS * `FPID_CLK_MHZ +
		`FPID_NS_PER_US - 1) / `FPID_NS_PER_US;
	localparam logic [15:0] DP_CYC = 16'(DP_RAW < 1 ? 1 : DP_RAW);
	localparam logic [15:0] RES1_CYC = 16'(RES1_RAW < 1 ? 1 : RES1_RAW);
	localparam logic [15:0] RES2_CYC = 16'(RES2_RAW < 1 ? 1 : RES2_RAW);

	logic [2:0] sck_s, csn_s;
	logic [3:0] io_m, io_s, chunk, io_o_r, io_oe_r;
	logic sck_rise, sck_fall, cs_rise, swap_r, opc_done, go;
	logic pend_dp_r, pend_rel_r, rel_id_r, powered_down_r, accepting_r;
	fpid_dst_t st_r;
	fpid_pm_t pm_r;
	fpid_fmt_t fmt_r, dec;
	logic [6:0] cnt_r, len, pos_r, pos_nxt, idx;
	logic [31:0] sh_r, sh_nxt;
	logic [7:0] op_r, opc;
	logic [15:0] tmr_r;
	logic [67:0] src;

	// ----------------------------------------------------------------
	// Link synchronisers and edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sck_s <= 3'h0;
			csn_s <= 3'h7;
			io_m <= 4'h0;
			io_s <= 4'h0;
		end else begin
			sck_s <= {sck_s[1:0], lnk.sclk};
			csn_s <= {csn_s[1:0], lnk.cs_n};
			io_m <= lnk.io;
			io_s <= io_m;
		end
	end

	assign sck_rise = sck_s[1] & ~sck_s[2] & ~csn_s[1];
	assign sck_fall = ~sck_s[1] & sck_s[2] & ~csn_s[1];
	assign cs_rise = csn_s[1] & ~csn_s[2];

	// ----------------------------------------------------------------
	// Command decoding
	// ----------------------------------------------------------------
	assign opc = {sh_r[6:0], io_s[0]};
	assign dec = fpid_fmt(opc);
	assign opc_done = sck_rise && st_r == FPID_ST_OPC &&
		cnt_r == `FPID_OPC_LAST;
	assign go = (pm_r == FPID_PM_NORMAL &&
		!(busy && opc == `FPID_OP_REL_EID)) ||
		(pm_r == FPID_PM_DOWN && opc == `FPID_OP_REL_EID);

	always_comb begin
		case (fmt_r.lanes)
			`FPID_LANES_2: sh_nxt = {sh_r[29:0], io_s[1:0]};
			`FPID_LANES_4: sh_nxt = {sh_r[27:0], io_s};
			default: sh_nxt = {sh_r[30:0], io_s[0]};
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= FPID_ST_OPC;
			cnt_r <= 7'h00;
			sh_r <= 32'h0;
			fmt_r <= '0;
			op_r <= 8'h00;
			swap_r <= 1'h0;
		end else if (cs_rise) begin
			st_r <= FPID_ST_OPC;
			cnt_r <= 7'h00;
		end else if (sck_rise) begin
			cnt_r <= cnt_r + 7'h01;
			case (st_r)
				FPID_ST_OPC: begin
					sh_r <= {sh_r[30:0], io_s[0]};
					if (cnt_r == `FPID_OPC_LAST) begin
						cnt_r <= 7'h00;
						op_r <= opc;
						fmt_r <= dec;
						swap_r <= 1'h0;
						if (!go || !dec.valid)
							st_r <= FPID_ST_IGN;
						else if (dec.in_clks != 6'h00)
							st_r <= FPID_ST_IN;
						else if (dec.dummy != 6'h00)
							st_r <= FPID_ST_DUMMY;
						else
							st_r <= FPID_ST_OUT;
					end
				end
				FPID_ST_IN: begin
					sh_r <= sh_nxt;
					if (cnt_r == 7'(fmt_r.in_clks) - 7'h01) begin
						cnt_r <= 7'h00;
						// Address bit 0 selects the byte order
						swap_r <= fmt_r.has_mode ? sh_nxt[8] : sh_nxt[0];
						st_r <= (fmt_r.dummy != 6'h00) ?
							FPID_ST_DUMMY : FPID_ST_OUT;
					end
				end
				FPID_ST_DUMMY: begin
					if (cnt_r == 7'(fmt_r.dummy) - 7'h01) begin
						cnt_r <= 7'h00;
						st_r <= FPID_ST_OUT;
					end
				end
				default: cnt_r <= 7'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pm_r <= FPID_PM_NORMAL;
			tmr_r <= 16'h0000;
			pend_dp_r <= 1'h0;
			pend_rel_r <= 1'h0;
			rel_id_r <= 1'h0;
			powered_down_r <= 1'h0;
			accepting_r <= 1'h1;
		end else begin
			powered_down_r <= pm_r == FPID_PM_DOWN;
			accepting_r <= pm_r == FPID_PM_NORMAL;
			if (opc_done) begin
				pend_dp_r <= go && opc == `FPID_OP_PD;
				pend_rel_r <= pm_r == FPID_PM_DOWN &&
					opc == `FPID_OP_REL_EID;
			end else if (sck_rise) begin
				// Any clock past the opcode cancels a pending power-down and turns a pending release into release with ID read
				pend_dp_r <= 1'h0;
				pend_rel_r <= 1'h0;
				if (pend_rel_r)
					rel_id_r <= 1'h1;
			end
			if (cs_rise) begin
				pend_dp_r <= 1'h0;
				pend_rel_r <= 1'h0;
				rel_id_r <= 1'h0;
				if (pend_dp_r) begin
					pm_r <= FPID_PM_ENTER;
					tmr_r <= DP_CYC;
				end else if (pend_rel_r) begin
					pm_r <= FPID_PM_REL;
					tmr_r <= RES1_CYC;
				end else if (rel_id_r) begin
					pm_r <= FPID_PM_REL;
					tmr_r <= RES2_CYC;
				end
			end else if (pm_r == FPID_PM_ENTER || pm_r == FPID_PM_REL) begin
				tmr_r <= tmr_r - 16'h0001;
				if (tmr_r == 16'h0001)
					pm_r <= (pm_r == FPID_PM_ENTER) ?
						FPID_PM_DOWN : FPID_PM_NORMAL;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read-out data
	// ----------------------------------------------------------------
	always_comb begin
		src = 68'h0;
		len = `FPID_LEN_EID;
		case (op_r)
			`FPID_OP_MD, `FPID_OP_MD_DUAL, `FPID_OP_MD_QUAD: begin
				src[67:52] = swap_r ? {DEV_ID, MFR_ID} :
					{MFR_ID, DEV_ID};
				len = `FPID_LEN_MD;
			end
			`FPID_OP_UID: begin
				src[67:4] = UNIQUE_ID;
				len = `FPID_LEN_UID;
			end
			`FPID_OP_JID: begin
				src[67:44] = {MFR_ID, MEM_TYPE, CAPACITY};
				len = `FPID_LEN_JID;
			end
			default: src[67:60] = ELEC_ID;
		endcase
	end

	assign idx = `FPID_SRC_TOP - pos_r;
	assign chunk = src[idx -: 4];
	assign pos_nxt = pos_r + 7'(fmt_r.lanes);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			io_o_r <= 4'h0;
			io_oe_r <= 4'h0;
			pos_r <= 7'h00;
		end else if (st_r != FPID_ST_OUT) begin
			io_oe_r <= 4'h0;
			pos_r <= 7'h00;
		end else if (sck_fall) begin
			case (fmt_r.lanes)
				`FPID_LANES_2: begin
					io_o_r <= {2'h0, chunk[3:2]};
					io_oe_r <= 4'h3;
				end
				`FPID_LANES_4: begin
					io_o_r <= chunk;
					io_oe_r <= 4'hf;
				end
				default: begin
					io_o_r <= {2'h0, chunk[3], 1'h0};
					io_oe_r <= 4'h2;
				end
			endcase
			// Sequence wraps so bytes repeat while clocked
			pos_r <= (pos_nxt >= len) ? 7'h00 : pos_nxt;
		end
	end

	assign lnk.dev_io_o = io_o_r;
	assign lnk.dev_io_oe = io_oe_r;
	assign powered_down = powered_down_r;
	assign accepting = accepting_r;
endmodule

// [hdl/fpid_host.sv]
// Host end: issues one command per request and gathers read data
`timescale 1ns/100ps
`include "fpid_defs.svh"

module fpid_host
	import fpid_pkg::*;
#(
	parameter int HALF_CYC = 4,
	parameter int T_GAP_NS = 5000
) (
	input wire logic mclk,
	input wire logic nrst,
	fpid_if.host lnk,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_op,
	input wire logic [23:0] cmd_addr,
	input wire logic [3:0] cmd_bytes,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [63:0] rsp_data
);

	localparam int GAP_RAW = (T_GAP_NS * `FPID_CLK_MHZ +
		`FPID_NS_PER_US - 1) / `FPID_NS_PER_US;
	localparam logic [15:0] GAP_CYC = 16'(GAP_RAW < 1 ? 1 : GAP_RAW);
	localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);

	fpid_hst_t st_r;
	fpid_fmt_t fmt_r;
	fpid_fmt_t dec;
	logic [7:0] div_r;
	logic sclk_r;
	logic csn_r;
	logic first_r;
	logic [3:0] io_o_r;
	logic [3:0] io_oe_r;
	logic [3:0] io_m;
	logic [3:0] io_s;
	logic [39:0] tx_r;
	logic [39:0] tx_nxt;
	logic [3:0] drv_o;
	logic [3:0] drv_oe;
	logic [6:0] k_r;
	logic [6:0] in_end_r;
	logic [6:0] rd_start_r;
	logic [6:0] end_r;
	logic [6:0] rd_clks;
	logic [6:0] rd_start;
	logic [63:0] rx_r;
	logic [63:0] rx_nxt;
	logic [15:0] gap_r;
	logic cmd_ready_r;
	logic rsp_valid_r;
	logic [63:0] rsp_data_r;

	// ----------------------------------------------------------------
	// Data pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			io_m <= 4'h0;
			io_s <= 4'h0;
		end else begin
			io_m <= lnk.io;
			io_s <= io_m;
		end
	end

	// ----------------------------------------------------------------
	// Command shape and per-clock pin data
	// ----------------------------------------------------------------
	assign dec = fpid_fmt(cmd_op);
	assign rd_start = `FPID_OPC_CLKS + 7'(dec.in_clks) + 7'(dec.dummy);

	always_comb begin
		case (dec.lanes)
			`FPID_LANES_2: rd_clks = {1'h0, cmd_bytes, 2'h0};
			`FPID_LANES_4: rd_clks = {2'h0, cmd_bytes, 1'h0};
			default: rd_clks = {cmd_bytes, 3'h0};
		endcase
	end

	always_comb begin
		drv_o = 4'h0;
		drv_oe = 4'h0;
		tx_nxt = tx_r;
		if (k_r < `FPID_OPC_CLKS) begin
			drv_o[0] = tx_r[39];
			drv_oe = 4'h1;
			tx_nxt = {tx_r[38:0], 1'h0};
		end else if (k_r < in_end_r) begin
			case (fmt_r.lanes)
				`FPID_LANES_2: begin
					drv_o[1:0] = tx_r[39:38];
					drv_oe = 4'h3;
					tx_nxt = {tx_r[37:0], 2'h0};
				end
				`FPID_LANES_4: begin
					drv_o = tx_r[39:36];
					drv_oe = 4'hf;
					tx_nxt = {tx_r[35:0], 4'h0};
				end
				default: begin
					drv_o[0] = tx_r[39];
					drv_oe = 4'h1;
					tx_nxt = {tx_r[38:0], 1'h0};
				end
			endcase
		end
	end

	always_comb begin
		case (fmt_r.lanes)
			`FPID_LANES_2: rx_nxt = {rx_r[61:0], io_s[1:0]};
			`FPID_LANES_4: rx_nxt = {rx_r[59:0], io_s};
			default: rx_nxt = {rx_r[62:0], io_s[1]};
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= FPID_H_IDLE;
			fmt_r <= '0;
			div_r <= 8'h00;
			sclk_r <= 1'h0;
			csn_r <= 1'h1;
			first_r <= 1'h0;
			io_o_r <= 4'h0;
			io_oe_r <= 4'h0;
			tx_r <= 40'h0;
			k_r <= 7'h00;
			in_end_r <= 7'h00;
			rd_start_r <= 7'h00;
			end_r <= 7'h00;
			rx_r <= 64'h0;
			gap_r <= 16'h0000;
			cmd_ready_r <= 1'h1;
			rsp_valid_r <= 1'h0;
			rsp_data_r <= 64'h0;
		end else begin
			rsp_valid_r <= 1'h0;
			case (st_r)
				FPID_H_IDLE: begin
					if (cmd_valid && cmd_ready_r) begin
						cmd_ready_r <= 1'h0;
						fmt_r <= dec;
						tx_r <= {cmd_op, cmd_addr, dec.has_mode ?
							`FPID_MODE_BITS_VAL : 8'h00};
						in_end_r <= `FPID_OPC_CLKS + 7'(dec.in_clks);
						rd_start_r <= rd_start;
						// Power-down or bare release ends after bit eight
						end_r <= (!dec.valid || (cmd_bytes == 4'h0 &&
							cmd_op == `FPID_OP_REL_EID)) ?
							`FPID_OPC_CLKS : rd_start + rd_clks;
						csn_r <= 1'h0;
						first_r <= 1'h1;
						div_r <= 8'h00;
						k_r <= 7'h00;
						rx_r <= 64'h0;
						st_r <= FPID_H_RUN;
					end
				end
				FPID_H_RUN: begin
					if (div_r != DIV_LAST) begin
						div_r <= div_r + 8'h01;
					end else if (!sclk_r && !first_r) begin
						div_r <= 8'h00;
						sclk_r <= 1'h1;
					end else begin
						div_r <= 8'h00;
						sclk_r <= 1'h0;
						first_r <= 1'h0;
						if (!first_r && k_r > rd_start_r)
							rx_r <= rx_nxt;
						if (k_r == end_r) begin
							csn_r <= 1'h1;
							io_oe_r <= 4'h0;
							gap_r <= GAP_CYC;
							rsp_valid_r <= 1'h1;
							rsp_data_r <= (k_r > rd_start_r) ? rx_nxt : rx_r;
							st_r <= FPID_H_GAP;
						end else begin
							io_o_r <= drv_o;
							io_oe_r <= drv_oe;
							tx_r <= tx_nxt;
							k_r <= k_r + 7'h01;
						end
					end
				end
				FPID_H_GAP: begin
					// Select stays high over every release delay
					gap_r <= gap_r - 16'h0001;
					if (gap_r == 16'h0001) begin
						cmd_ready_r <= 1'h1;
						st_r <= FPID_H_IDLE;
					end
				end
				default: st_r <= FPID_H_IDLE;
			endcase
		end
	end

	assign lnk.sclk = sclk_r;
	assign lnk.cs_n = csn_r;
	assign lnk.host_io_o = io_o_r;
	assign lnk.host_io_oe = io_oe_r;
	assign cmd_ready = cmd_ready_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
endmodule

// [hdl/fpid_if.sv]
// Serial link between host and device, with pin resolution
`timescale 1ns/100ps
interface fpid_if;
	logic sclk;
	logic cs_n;
	logic [3:0] host_io_o;
	logic [3:0] host_io_oe;
	logic [3:0] dev_io_o;
	logic [3:0] dev_io_oe;
	logic [3:0] io;

	// ----------------------------------------------------------------
	// Pin levels: device wins, else host, else pull-up
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_pin
			assign io[i] = dev_io_oe[i] ? dev_io_o[i] :
				(host_io_oe[i] ? host_io_o[i] : 1'h1);
		end
	endgenerate

	modport dev (input sclk, input cs_n, input io,
		output dev_io_o, output dev_io_oe);
	modport host (output sclk, output cs_n, output host_io_o,
		output host_io_oe, input io);
endinterface

// [hdl/fpid_pkg.sv]
// Types and opcode format table shared by both ends of the link
package fpid_pkg;
`include "fpid_defs.svh"

	typedef struct packed {
		logic valid;
		logic [2:0] lanes;
		logic [5:0] in_clks;
		logic [5:0] dummy;
		logic has_mode;
	} fpid_fmt_t;

	typedef enum logic [2:0] {
		FPID_ST_OPC = 3'b000,
		FPID_ST_IN = 3'b001,
		FPID_ST_DUMMY = 3'b010,
		FPID_ST_OUT = 3'b011,
		FPID_ST_IGN = 3'b100
	} fpid_dst_t;

	typedef enum logic [1:0] {
		FPID_PM_NORMAL = 2'b00,
		FPID_PM_ENTER = 2'b01,
		FPID_PM_DOWN = 2'b10,
		FPID_PM_REL = 2'b11
	} fpid_pm_t;

	typedef enum logic [1:0] {
		FPID_H_IDLE = 2'b00,
		FPID_H_RUN = 2'b01,
		FPID_H_GAP = 2'b10
	} fpid_hst_t;

	// Phases that follow each opcode; power-down carries no read
	function automatic fpid_fmt_t fpid_fmt(input logic [7:0] op);
		fpid_fmt_t f;
		f = '0;
		f.lanes = `FPID_LANES_1;
		f.valid = 1'h1;
		case (op)
			`FPID_OP_MD: f.in_clks = `FPID_ADDR_CLKS_1;
			`FPID_OP_MD_DUAL: begin
				f.lanes = `FPID_LANES_2;
				f.in_clks = `FPID_IN_CLKS_DUAL;
				f.has_mode = 1'h1;
			end
			`FPID_OP_MD_QUAD: begin
				f.lanes = `FPID_LANES_4;
				f.in_clks = `FPID_IN_CLKS_QUAD;
				f.dummy = `FPID_DUMMY_QUAD;
				f.has_mode = 1'h1;
			end
			`FPID_OP_REL_EID: f.dummy = `FPID_DUMMY_EID;
			`FPID_OP_UID: f.dummy = `FPID_DUMMY_UID;
			`FPID_OP_JID: f.valid = 1'h1;
			default: f.valid = 1'h0;
		endcase
		return f;
	endfunction
endpackage

// [sim/fpid_link_sva.sv]
// Assertions on the serial link between the host and device ends
`timescale 1ns/100ps
module fpid_link_sva (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] host_io_o,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_o,
	input wire logic [3:0] dev_io_oe,
	input wire logic [3:0] io
);
	localparam int RES_CYC = 30;
	logic [7:0] cs_hi_r;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Cycles spent with chip select high, saturating
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cs_hi_r <= 8'hff;
		end else if (!cs_n) begin
			cs_hi_r <= 8'h00;
		end else if (cs_hi_r != 8'hff) begin
			cs_hi_r <= cs_hi_r + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	a_oe_lane_set: assert property (
		dev_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("device drives an odd set of lanes");
	a_release_oe: assert property (
		$rose(cs_n) |-> ##[1:5] (dev_io_oe == 4'h0))
		else $error("device kept driving after deselect");
	a_idle_quiet: assert property (cs_n [*6] |-> dev_io_oe == 4'h0)
		else $error("device drives while deselected");
	a_oe_on_fall: assert property (
		(|(dev_io_oe & ~$past(dev_io_oe))) |-> !sclk)
		else $error("device output enabled while clock high");
	a_out_on_fall: assert property ((!cs_n && dev_io_oe != 4'h0 &&
		$stable(dev_io_oe) && $changed(dev_io_o)) |-> !sclk)
		else $error("device output changed while clock high");
	a_host_holds_io: assert property (
		(sclk && $past(sclk)) |-> $stable(host_io_o))
		else $error("host data moved while clock high");
	a_sclk_high_len: assert property (
		$rose(sclk) |-> sclk [*4] ##1 !sclk)
		else $error("serial clock high phase wrong length");
	a_sclk_low_len: assert property ($fell(sclk) |-> (!sclk) [*4])
		else $error("serial clock low phase too short");
	a_cs_gap: assert property ($fell(cs_n) |-> cs_hi_r >= RES_CYC)
		else $error("chip select high time too short");
	a_no_contention: assert property (!(|(dev_io_oe & host_io_oe)))
		else $error("host and device drive one lane together");

	c_quad: cover property (dev_io_oe == 4'hf);
	c_dual: cover property (dev_io_oe == 4'h3);
	c_single: cover property (dev_io_oe == 4'h2 && io[1] == 1'h0);
endmodule

// [sim/test_flash_powerdown_and_id_commands.sv]
// Self-checking bench joining host and device ends over the link
`timescale 1ns/100ps
`include "fpid_defs.svh"
module test_flash_powerdown_and_id_commands;
	// Identity values are arbitrary
	localparam logic [7:0] MFR = 8'h5a;
	localparam logic [7:0] DEV = 8'h13;
	localparam logic [7:0] MEM = 8'h60;
	localparam logic [7:0] CAP = 8'h14;
	localparam logic [7:0] EID = 8'h13;
	localparam logic [63:0] UID = 64'h0123456789abcdef;
	logic mclk = 1'h0;
	logic nrst, busy, cmd_valid, cmd_ready, rsp_valid;
	logic powered_down, accepting;
	logic [7:0] cmd_op;
	logic [23:0] cmd_addr;
	logic [3:0] cmd_bytes;
	logic [63:0] rsp_data;
	int fails, tests_run;

	always #50 mclk = ~mclk;

	fpid_if fpid_if_inst();
	fpid_host #(.HALF_CYC(4), .T_GAP_NS(5000)) fpid_host_inst (
		.mclk(mclk), .nrst(nrst), .lnk(fpid_if_inst.host),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_bytes(cmd_bytes), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	fpid_dev #(.T_DP_NS(3000), .T_RES1_NS(3000), .T_RES2_NS(1800),
		.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEM), .CAPACITY(CAP),
		.ELEC_ID(EID), .UNIQUE_ID(UID)) fpid_dev_inst (
		.mclk(mclk), .nrst(nrst), .lnk(fpid_if_inst.dev), .busy(busy),
		.powered_down(powered_down), .accepting(accepting));
	fpid_link_sva fpid_link_sva_inst (.mclk(mclk), .nrst(nrst),
		.sclk(fpid_if_inst.sclk), .cs_n(fpid_if_inst.cs_n),
		.host_io_o(fpid_if_inst.host_io_o),
		.host_io_oe(fpid_if_inst.host_io_oe),
		.dev_io_o(fpid_if_inst.dev_io_o),
		.dev_io_oe(fpid_if_inst.dev_io_oe), .io(fpid_if_inst.io));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic run_cmd(input logic [7:0] op, input logic [23:0] addr,
		input logic [3:0] nb, output logic [63:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'h1 && n < 200) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 200) begin
			fails++;
			stop_test();
		end
		cmd_op = op;
		cmd_addr = addr;
		cmd_bytes = nb;
		cmd_valid = 1'h1;
		@(posedge mclk);
		#1;
		cmd_valid = 1'h0;
		while (rsp_valid !== 1'h1 && n < 2000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 2000) begin
			fails++;
			stop_test();
		end
		d = rsp_data;
	endtask

	task automatic read_chk(input logic [7:0] op, input logic [23:0] addr,
		input logic [3:0] nb, input logic [63:0] exp);
		logic [63:0] d;
		logic [63:0] mask;
		run_cmd(op, addr, nb, d);
		mask = (64'h1 << (nb * 8)) - 64'h1;
		check(d & mask, exp);
	endtask

	// Cycles until powered_down (pd_want) or accepting rises
	task automatic wait_level(input logic pd_want, output int n);
		n = 0;
		while (n < 80 && (pd_want ? powered_down : accepting) !== 1'h1) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 80) begin
			fails++;
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		check({62'h0, powered_down, accepting}, 64'h1);
	endtask

	task automatic t_ids();
		read_chk(8'h05, 24'h0, 4'h1, 64'h0);
		read_chk(`FPID_OP_JID, 24'h0, 4'h3, {MFR, MEM, CAP});
		read_chk(`FPID_OP_MD, 24'h0, 4'h4, {MFR, DEV, MFR, DEV});
		read_chk(`FPID_OP_MD, 24'h1, 4'h3, {DEV, MFR, DEV});
		read_chk(`FPID_OP_MD_DUAL, 24'h0, 4'h2, {MFR, DEV});
		read_chk(`FPID_OP_MD_QUAD, 24'h1, 4'h4, {DEV, MFR, DEV, MFR});
		read_chk(`FPID_OP_UID, 24'h0, 4'h8, UID);
		read_chk(`FPID_OP_REL_EID, 24'h0, 4'h3, {EID, EID, EID});
	endtask

	task automatic t_powerdown();
		logic [63:0] d;
		int n;
		run_cmd(`FPID_OP_PD, 24'h0, 4'h0, d);
		wait_level(1'h1, n);
		check({63'h0, n >= 30 && n <= 40}, 64'h1);
		read_chk(`FPID_OP_JID, 24'h0, 4'h3, 64'hffffff);
		read_chk(8'h05, 24'h0, 4'h1, 64'h0);
		check({63'h0, powered_down}, 64'h1);
		run_cmd(`FPID_OP_REL_EID, 24'h0, 4'h0, d);
		wait_level(1'h0, n);
		check({63'h0, n >= 30 && n <= 40}, 64'h1);
		check({63'h0, powered_down}, 64'h0);
		read_chk(`FPID_OP_JID, 24'h0, 4'h3, {MFR, MEM, CAP});
	endtask

	task automatic t_rel_id();
		logic [63:0] d;
		int n;
		run_cmd(`FPID_OP_PD, 24'h0, 4'h0, d);
		wait_level(1'h1, n);
		run_cmd(`FPID_OP_REL_EID, 24'h0, 4'h1, d);
		check(d, {56'h0, EID});
		wait_level(1'h0, n);
		check({63'h0, n >= 18 && n < 30}, 64'h1);
		read_chk(`FPID_OP_MD, 24'h0, 4'h2, {MFR, DEV});
	endtask

	task automatic t_busy();
		@(posedge mclk);
		#1;
		busy = 1'h1;
		read_chk(`FPID_OP_REL_EID, 24'h0, 4'h1, 64'hff);
		busy = 1'h0;
		read_chk(`FPID_OP_REL_EID, 24'h0, 4'h2, {EID, EID});
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'h0;
		busy = 1'h0;
		cmd_valid = 1'h0;
		cmd_op = 8'h00;
		cmd_addr = 24'h000000;
		cmd_bytes = 4'h0;
		fails = 0;
		tests_run = 0;
		repeat (6) @(posedge mclk);
		#1;
		nrst = 1'h1;
		t_reset();
		t_ids();
		t_powerdown();
		t_rel_id();
		t_busy();
		stop_test();
	end
endmodule
